// ---- include/bstp_pkg.sv ----
package bstp_pkg;
  // ===========================================================
  // pin map of the shared general-purpose pins
  localparam int unsigned NGPIO    = 5;
  localparam int unsigned PIN_TCK  = 0;
  localparam int unsigned PIN_TMS  = 1;
  localparam int unsigned PIN_TDI  = 2;
  localparam int unsigned PIN_TDO  = 3;
  localparam int unsigned PIN_TRST = 4;

  // ===========================================================
  // boundary chain: input cells low, output cells high
  localparam int unsigned NB_IN   = 4;
  localparam int unsigned NB_OUT  = 8;
  localparam int unsigned BSR_LEN = NB_IN + NB_OUT;
  localparam int unsigned ID_LEN  = 32;
  localparam int unsigned SYNC_W  = NGPIO + NB_IN + 1;

  // ===========================================================
  // instruction register
  localparam int unsigned IR_LEN = 4;
  localparam logic [IR_LEN-1:0] IR_EXTEST  = 4'h0;
  localparam logic [IR_LEN-1:0] IR_IDCODE  = 4'h1;
  localparam logic [IR_LEN-1:0] IR_SAMPLE  = 4'h2;
  localparam logic [IR_LEN-1:0] IR_PRELOAD = 4'h3;
  localparam logic [IR_LEN-1:0] IR_HIGHZ   = 4'h4;
  localparam logic [IR_LEN-1:0] IR_CLAMP   = 4'h5;
  localparam logic [IR_LEN-1:0] IR_BYPASS  = 4'hF;
  localparam logic [IR_LEN-1:0] IR_CAPTURE = 4'h1;

  // ===========================================================
  // controller states, gray along the usual walk
  typedef enum logic [3:0] {
    ST_TLR   = 4'h0, ST_RTI   = 4'h1, ST_SELDR = 4'h3, ST_CAPDR = 4'h2,
    ST_SHDR  = 4'h6, ST_EX1DR = 4'h7, ST_PSDR  = 4'h5, ST_EX2DR = 4'h4,
    ST_UPDR  = 4'hC, ST_SELIR = 4'hD, ST_CAPIR = 4'hF, ST_SHIR  = 4'hE,
    ST_EX1IR = 4'hA, ST_PSIR  = 4'hB, ST_EX2IR = 4'h9, ST_UPIR  = 4'h8
  } bstp_state_t;
endpackage : bstp_pkg

// ---- src/bstp_sync.sv ----
`timescale 1ns/1ps
module bstp_sync #(
  parameter int unsigned      W       = 1,
  parameter logic [W-1:0]     RST_VAL = '0
) (
  input  wire logic           clk,
  input  wire logic           rstn,
  input  wire logic [W-1:0]   d,
  output logic      [W-1:0]   q
);
  logic [W-1:0] meta_reg;

  // ===========================================================
  // two-stage synchroniser, one per bit
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          meta_reg[i] <= RST_VAL[i];
          q[i]        <= RST_VAL[i];
        end else begin
          meta_reg[i] <= d[i];
          q[i]        <= meta_reg[i];
        end
      end
    end
  endgenerate
endmodule : bstp_sync

// ---- src/bstp_top.sv ----
`timescale 1ns/1ps
module bstp_top
  import bstp_pkg::*;
#(
  // arbitrary neutral identity, lsb must be one
  parameter logic [31:0] ID_VALUE = 32'h0000_1001
) (
  input  wire logic                    clk,
  input  wire logic                    rstn,
  input  wire logic                    test_mode_pin_n,
  input  wire logic [bstp_pkg::NGPIO-1:0]  gpio_in,
  output logic      [bstp_pkg::NGPIO-1:0]  gpio_out,
  output logic      [bstp_pkg::NGPIO-1:0]  gpio_oe,
  input  wire logic [bstp_pkg::NGPIO-1:0]  gpio_func_out,
  input  wire logic [bstp_pkg::NGPIO-1:0]  gpio_func_oe,
  output logic      [bstp_pkg::NGPIO-1:0]  gpio_func_in,
  input  wire logic [bstp_pkg::NB_IN-1:0]  pad_in,
  output logic      [bstp_pkg::NB_IN-1:0]  core_in,
  input  wire logic [bstp_pkg::NB_OUT-1:0] core_out,
  input  wire logic                    core_oe,
  output logic      [bstp_pkg::NB_OUT-1:0] pad_out,
  output logic                         pad_oe,
  output logic                         halt
);
  import bstp_pkg::*;

  // ===========================================================
  // pin sampling
  logic [SYNC_W-1:0] sync_q;
  logic [NGPIO-1:0]  gpio_s;
  logic [NB_IN-1:0]  pad_s;
  logic              test_n_s;

  bstp_sync #(
    .W       (SYNC_W),
    .RST_VAL ({1'b1, {(NB_IN+NGPIO){1'b0}}})
  ) u_sync (
    .clk  (clk),
    .rstn (rstn),
    .d    ({test_mode_pin_n, pad_in, gpio_in}),
    .q    (sync_q)
  );

  assign gpio_s   = sync_q[NGPIO-1:0];
  assign pad_s    = sync_q[NGPIO+NB_IN-1:NGPIO];
  assign test_n_s = sync_q[SYNC_W-1];

  logic active;
  logic trst_s;
  logic tck_rise;
  logic tck_fall;
  logic tck_reg;
  logic tck_next;

  assign active   = !test_n_s;
  assign trst_s   = gpio_s[PIN_TRST];
  assign tck_next = gpio_s[PIN_TCK];
  assign tck_rise = active && tck_next && !tck_reg;
  assign tck_fall = active && !tck_next && tck_reg;

  // ===========================================================
  // helpers
  function automatic bstp_state_t tap_next(bstp_state_t s, logic tms);
    unique case (s)
      ST_TLR:   tap_next = tms ? ST_TLR   : ST_RTI;
      ST_RTI:   tap_next = tms ? ST_SELDR : ST_RTI;
      ST_SELDR: tap_next = tms ? ST_SELIR : ST_CAPDR;
      ST_CAPDR: tap_next = tms ? ST_EX1DR : ST_SHDR;
      ST_SHDR:  tap_next = tms ? ST_EX1DR : ST_SHDR;
      ST_EX1DR: tap_next = tms ? ST_UPDR  : ST_PSDR;
      ST_PSDR:  tap_next = tms ? ST_EX2DR : ST_PSDR;
      ST_EX2DR: tap_next = tms ? ST_UPDR  : ST_SHDR;
      ST_UPDR:  tap_next = tms ? ST_SELDR : ST_RTI;
      ST_SELIR: tap_next = tms ? ST_TLR   : ST_CAPIR;
      ST_CAPIR: tap_next = tms ? ST_EX1IR : ST_SHIR;
      ST_SHIR:  tap_next = tms ? ST_EX1IR : ST_SHIR;
      ST_EX1IR: tap_next = tms ? ST_UPIR  : ST_PSIR;
      ST_PSIR:  tap_next = tms ? ST_EX2IR : ST_PSIR;
      ST_EX2IR: tap_next = tms ? ST_UPIR  : ST_SHIR;
      ST_UPIR:  tap_next = tms ? ST_SELDR : ST_RTI;
    endcase
  endfunction : tap_next

  function automatic logic uses_bsr(logic [IR_LEN-1:0] ir);
    uses_bsr = (ir == IR_EXTEST) || (ir == IR_SAMPLE) ||
               (ir == IR_PRELOAD);
  endfunction : uses_bsr

  function automatic logic drives_pins(logic [IR_LEN-1:0] ir);
    drives_pins = (ir == IR_EXTEST) || (ir == IR_CLAMP);
  endfunction : drives_pins

  // ===========================================================
  // controller and scan registers
  bstp_state_t          state_reg,  state_next;
  logic [IR_LEN-1:0]    ir_reg,     ir_next;
  logic [IR_LEN-1:0]    irsh_reg,   irsh_next;
  logic [ID_LEN-1:0]    idsh_reg,   idsh_next;
  logic [BSR_LEN-1:0]   bsh_reg,    bsh_next;
  logic [BSR_LEN-1:0]   bupd_reg,   bupd_next;
  logic                 byp_reg,    byp_next;
  logic                 tdo_reg,    tdo_next;
  logic                 tdoen_reg,  tdoen_next;
  logic                 dr_bit;
  logic                 tdi_s;
  logic                 tms_s;

  assign tdi_s = gpio_s[PIN_TDI];
  assign tms_s = gpio_s[PIN_TMS];

  always_comb begin
    if (ir_reg == IR_IDCODE) begin
      dr_bit = idsh_reg[0];
    end else if (uses_bsr(ir_reg)) begin
      dr_bit = bsh_reg[0];
    end else begin
      dr_bit = byp_reg;
    end
  end

  always_comb begin
    state_next = state_reg;
    ir_next    = ir_reg;
    irsh_next  = irsh_reg;
    idsh_next  = idsh_reg;
    bsh_next   = bsh_reg;
    bupd_next  = bupd_reg;
    byp_next   = byp_reg;
    tdo_next   = tdo_reg;
    tdoen_next = tdoen_reg;
    if (!active || !trst_s) begin
      state_next = ST_TLR;
      ir_next    = IR_IDCODE;
      tdoen_next = 1'b0;
    end else if (tck_rise) begin
      state_next = tap_next(state_reg, tms_s);
      unique case (state_reg)
        ST_CAPIR: irsh_next = IR_CAPTURE;
        ST_SHIR:  irsh_next = {tdi_s, irsh_reg[IR_LEN-1:1]};
        ST_CAPDR: begin
          idsh_next = ID_VALUE;
          bsh_next  = {core_out, pad_s};
          byp_next  = 1'b0;
        end
        ST_SHDR: begin
          idsh_next = {tdi_s, idsh_reg[ID_LEN-1:1]};
          bsh_next  = {tdi_s, bsh_reg[BSR_LEN-1:1]};
          byp_next  = tdi_s;
        end
        default: ;
      endcase
    end else if (tck_fall) begin
      tdo_next   = (state_reg == ST_SHIR) ? irsh_reg[0] : dr_bit;
      tdoen_next = (state_reg == ST_SHIR) || (state_reg == ST_SHDR);
      if (state_reg == ST_TLR) begin
        ir_next = IR_IDCODE;
      end else if (state_reg == ST_UPIR) begin
        ir_next = irsh_reg;
      end else if (state_reg == ST_UPDR && uses_bsr(ir_reg)) begin
        bupd_next = bsh_reg;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_TLR;
      ir_reg    <= IR_IDCODE;
      irsh_reg  <= '0;
      idsh_reg  <= '0;
      bsh_reg   <= '0;
      bupd_reg  <= '0;
      byp_reg   <= 1'b0;
      tdo_reg   <= 1'b0;
      tdoen_reg <= 1'b0;
      tck_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      ir_reg    <= ir_next;
      irsh_reg  <= irsh_next;
      idsh_reg  <= idsh_next;
      bsh_reg   <= bsh_next;
      bupd_reg  <= bupd_next;
      byp_reg   <= byp_next;
      tdo_reg   <= tdo_next;
      tdoen_reg <= tdoen_next;
      tck_reg   <= tck_next;
    end
  end

  // ===========================================================
  // pin muxing and boundary outputs
  logic [NGPIO-1:0]  gout_next;
  logic [NGPIO-1:0]  goe_next;
  logic [NB_OUT-1:0] pout_next;
  logic              poe_next;

  always_comb begin
    gout_next = gpio_func_out;
    goe_next  = gpio_func_oe;
    pout_next = core_out;
    poe_next  = core_oe;
    if (active) begin
      gout_next          = '0;
      goe_next           = '0;
      gout_next[PIN_TDO] = tdo_reg;
      goe_next[PIN_TDO]  = tdoen_reg;
      // while halted the core drives nothing of its own
      pout_next = '0;
      poe_next  = 1'b0;
      if (drives_pins(ir_reg)) begin
        pout_next = bupd_reg[BSR_LEN-1:NB_IN];
        poe_next  = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gpio_out     <= '0;
      gpio_oe      <= '0;
      gpio_func_in <= '0;
      core_in      <= '0;
      pad_out      <= '0;
      pad_oe       <= 1'b0;
      halt         <= 1'b0;
    end else begin
      gpio_out     <= gout_next;
      gpio_oe      <= goe_next;
      gpio_func_in <= active ? '0 : gpio_s;
      core_in      <= pad_s;
      pad_out      <= pout_next;
      pad_oe       <= poe_next;
      halt         <= active;
    end
  end

  // ===========================================================
  // checks
  property p_halt;
    @(posedge clk) disable iff (!rstn)
    $fell(test_n_s) |=> halt ##1 $stable(halt) or test_n_s;
  endproperty
  a_halt: assert property (p_halt) else $error("no halt in test mode");

  property p_idle_tap;
    @(posedge clk) disable iff (!rstn)
    !active |=> state_reg == ST_TLR && !tdoen_reg;
  endproperty
  a_idle_tap: assert property (p_idle_tap) else $error("port live");

  property p_gpio_pass;
    @(posedge clk) disable iff (!rstn)
    !active |=> gpio_oe == $past(gpio_func_oe);
  endproperty
  a_gpio_pass: assert property (p_gpio_pass) else $error("gpio oe");

  property p_scan_inputs;
    @(posedge clk) disable iff (!rstn)
    active |=> gpio_oe[PIN_TCK] == 1'b0 && gpio_oe[PIN_TMS] == 1'b0 &&
               gpio_oe[PIN_TDI] == 1'b0 && gpio_oe[PIN_TRST] == 1'b0;
  endproperty
  a_scan_inputs: assert property (p_scan_inputs) else $error("in driven");

  property p_trst;
    @(posedge clk) disable iff (!rstn)
    !trst_s |=> state_reg == ST_TLR && ir_reg == IR_IDCODE;
  endproperty
  a_trst: assert property (p_trst) else $error("trst ignored");

  property p_ir_shift;
    @(posedge clk) disable iff (!rstn)
    tck_rise && trst_s && state_reg == ST_SHIR
      |=> irsh_reg[IR_LEN-1] == $past(tdi_s);
  endproperty
  a_ir_shift: assert property (p_ir_shift) else $error("tdi lost");

  property p_hold;
    @(posedge clk) disable iff (!rstn)
    active && trst_s && !tck_rise |=> $stable(state_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("step off tck");

  property p_tdo_fall;
    @(posedge clk) disable iff (!rstn)
    tck_fall && trst_s && state_reg == ST_SHDR
      |=> tdo_reg == $past(dr_bit) ##1 gpio_out[PIN_TDO] == tdo_reg;
  endproperty
  a_tdo_fall: assert property (p_tdo_fall) else $error("tdo late");

  property p_highz;
    @(posedge clk) disable iff (!rstn)
    active && ir_reg == IR_HIGHZ |=> !pad_oe;
  endproperty
  a_highz: assert property (p_highz) else $error("pads driven");
endmodule : bstp_top

// ---- verif/bstp_tester.sv ----
`timescale 1ns/1ps
module bstp_tester (
  input  wire logic clk,
  input  wire logic tdo,
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  output logic      trst_n
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    trst_n = 1'b1;
  end

  // ==========================================================
  // one scan bit: fall, data early in the low phase, rise, read
  // read late in the high phase, the port's sync delay eats the rest
  task automatic cyc(input logic m, input logic d, output logic q);
    @(posedge clk) tck <= 1'b0;
    @(posedge clk);
    tms <= m;
    tdi <= d;
    repeat (3) @(posedge clk);
    tck <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk) q = tdo;
  endtask : cyc

  // ==========================================================
  // port reset, held well past the pin synchroniser
  task automatic reset_tap();
    @(posedge clk) trst_n <= 1'b0;
    repeat (6) @(posedge clk);
    trst_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask : reset_tap
endmodule : bstp_tester

// ---- verif/tb_boundary_scan_test_port.sv ----
`timescale 1ns/1ps
module tb_boundary_scan_test_port;
  import bstp_pkg::*;
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin failures++; \
  $display("Error at %0t ns: got %h expected %h", $time, (a), (e)); end end

  typedef struct {
    logic [IR_LEN-1:0] code;
    int                len;
    logic [7:0]        src;
    logic              oe;
    logic [7:0]        pad;
  } bstp_row_t;

  // arbitrary identity value, lsb set
  localparam logic [31:0] ID    = 32'h0000_5A03;
  localparam logic [7:0]  CORE  = 8'hC6;
  localparam logic [3:0]  PADIN = 4'h9;

  // clamp must drive what preload left, so order matters
  bstp_row_t rows [8] = '{
    '{IR_PRELOAD, 12, 8'h5A, 1'b0, 8'h00},
    '{IR_CLAMP,    1, 8'hFF, 1'b1, 8'h5A},
    '{IR_EXTEST,  12, 8'h3C, 1'b1, 8'h3C},
    '{IR_SAMPLE,  12, 8'h81, 1'b0, 8'h00},
    '{IR_HIGHZ,    1, 8'h00, 1'b0, 8'h00},
    '{IR_IDCODE,  32, 8'h00, 1'b0, 8'h00},
    '{IR_BYPASS,   1, 8'h00, 1'b0, 8'h00},
    '{4'h7,        1, 8'h00, 1'b0, 8'h00}};

  logic              clk;
  logic              rstn;
  logic              test_mode_pin_n;
  logic              flt;
  logic              tck;
  logic              tms;
  logic              tdi;
  logic              trst_n;
  logic [NGPIO-1:0]  ext;
  logic [NGPIO-1:0]  pin;
  logic [NGPIO-1:0]  gpio_out;
  logic [NGPIO-1:0]  gpio_oe;
  logic [NGPIO-1:0]  gpio_func_in;
  logic [NB_IN-1:0]  core_in;
  logic [NB_OUT-1:0] pad_out;
  logic              pad_oe;
  logic              halt;
  logic              q;
  logic [47:0]       din;
  logic [47:0]       dout;
  logic [47:0]       cap;
  int                failures;
  int                n_checks;

  // ==========================================================
  // pins: an undriven data pin wanders, no pull on the board
  assign ext = {trst_n, flt, tdi, tms, tck};
  assign pin = (gpio_oe & gpio_out) | (~gpio_oe & ext);
  always @(posedge clk) flt <= ~flt;
  always #50 clk = ~clk;

  bstp_top #(.ID_VALUE(ID)) u_dut (
    .clk(clk), .rstn(rstn), .test_mode_pin_n(test_mode_pin_n),
    .gpio_in(pin), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .gpio_func_out(5'h1A), .gpio_func_oe(5'h08),
    .gpio_func_in(gpio_func_in), .pad_in(PADIN), .core_in(core_in),
    .core_out(CORE), .core_oe(1'b1), .pad_out(pad_out),
    .pad_oe(pad_oe), .halt(halt));

  bstp_tester u_tap (.clk(clk), .tdo(pin[PIN_TDO]), .tck(tck),
    .tms(tms), .tdi(tdi), .trst_n(trst_n));

  // ==========================================================
  // walk from idle by pre, shift n bits, update, back to idle
  task automatic scan(input logic [3:0] pre, input int np, input int n,
                      input logic [47:0] d, output logic [47:0] o);
    logic b;
    o = '0;
    for (int i = 0; i < np; i++) u_tap.cyc(pre[i], 1'b0, b);
    for (int i = 0; i < n; i++) begin
      u_tap.cyc(i == n - 1, d[i], b);
      o[i] = b;
    end
    u_tap.cyc(1'b1, 1'b0, b);
    u_tap.cyc(1'b0, 1'b0, b);
  endtask : scan

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done

  task automatic results();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results

  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    $display("Error at %0t ns: watchdog got %h expected %h", $time, 0, 1);
    results();
  end

  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    test_mode_pin_n = 1'b1;
    flt = 1'b0;
    failures = 0;
    n_checks = 0;
    repeat (10) @(negedge clk);
    `CHK({halt, pad_oe, gpio_oe}, 7'h00)
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (8) @(negedge clk);
    `CHK(halt, 1'b0)
    `CHK({gpio_out, gpio_oe, gpio_func_in}, {5'h1A, 5'h08, 5'h1A})
    `CHK({pad_oe, pad_out, core_in}, {1'b1, CORE, PADIN})
    done("normal mode");
    @(posedge clk) test_mode_pin_n <= 1'b0;
    repeat (6) @(negedge clk);
    `CHK({halt, pad_oe}, 2'b10)
    `CHK({gpio_oe, gpio_func_in}, 10'h000)
    u_tap.cyc(1'b0, 1'b0, q);
    scan(4'h1, 3, 32, 48'h0, dout);
    `CHK(dout[31:0], ID)
    done("identity after reset");
    foreach (rows[k]) begin
      scan(4'h3, 4, 4, {44'h0, rows[k].code}, dout);
      `CHK(dout[3:0], 4'h1)
      din = {rows[k].src, 40'hC3_96F0_1E2D};
      cap = rows[k].len == 32 ? {16'h0, ID} :
            rows[k].len == 12 ? {36'h0, CORE, PADIN} : 48'h0;
      scan(4'h1, 3, 48, din, dout);
      `CHK(dout, (din << rows[k].len) | cap)
      repeat (4) @(negedge clk);
      `CHK({pad_oe, pad_out}, {rows[k].oe, rows[k].pad})
      done("instruction row");
    end
    // port reset in mid-walk must drop the bypass choice
    u_tap.cyc(1'b1, 1'b0, q);
    u_tap.reset_tap();
    u_tap.cyc(1'b0, 1'b0, q);
    scan(4'h1, 3, 32, 48'h0, dout);
    `CHK(dout[31:0], ID)
    done("port reset mid walk");
    u_tap.cyc(1'b1, 1'b0, q);
    @(posedge clk) test_mode_pin_n <= 1'b1;
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (8) @(negedge clk);
    `CHK(halt, 1'b0)
    `CHK({gpio_out, gpio_oe, gpio_func_in}, {5'h1A, 5'h08, 5'h1B})
    done("leave test mode");
    results();
  end
endmodule : tb_boundary_scan_test_port
